//--- tb/tcc_pin_src.sv
`timescale 1ns/100ps
// External clock source: a burst of 8 edges, 5 cycles apart, then still
module tcc_pin_src (
  input  wire logic       i_mclk,
  input  wire logic [1:0] i_pin,
  input  wire logic       i_go,
  output logic [3:0]      o_pins,
  output logic            o_busy
);
  int         cnt    = 0;                  // Cycles left in the burst
  logic [3:0] pins_q = 4'h0;               // Pin levels, idle low
  // Slow edges so the two-stage synchroniser sees every one
  always @(posedge i_mclk) begin
    if (i_go && cnt == 0) begin
      cnt <= 40;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt % 5 == 1) begin
        pins_q[i_pin] <= ~pins_q[i_pin];
      end
    end
  end
  assign o_busy = (cnt != 0);
  assign o_pins = pins_q;
endmodule

//--- tb/tcc_timer_core_bench.sv
`timescale 1ns/100ps
module tcc_timer_core_bench;
  import tcc_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_standby = 1'b0;
  logic [6:0]  i_addr = 7'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [1:0]  i_be = 2'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic [3:0]  i_ext_clock;
  logic [4:0]  i_capture_a = 5'h00;
  logic [4:0]  i_capture_b = 5'h00;
  logic        i_quad_count_mode = 1'b0;
  logic        i_phase_up = 1'b0;
  logic        i_phase_down = 1'b0;
  logic [15:0] o_rdata;
  logic [4:0]  o_cmatch_a;
  logic [4:0]  o_cmatch_b;
  logic [1:0]  pin_sel = 2'h0;
  logic        pin_go = 1'b0;
  logic        pin_busy;
  int          n_errors = 0;
  int          num_checks = 0;
  tcc_timer_core #(.NCH(5)) dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_standby(i_standby),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_be(i_be), .i_wdata(i_wdata),
    .i_ext_clock(i_ext_clock), .i_capture_a(i_capture_a), .i_capture_b(i_capture_b),
    .i_quad_count_mode(i_quad_count_mode), .i_phase_up(i_phase_up),
    .i_phase_down(i_phase_down), .o_rdata(o_rdata), .o_cmatch_a(o_cmatch_a),
    .o_cmatch_b(o_cmatch_b));
  tcc_pin_src pin_u (.i_mclk(i_mclk), .i_pin(pin_sel), .i_go(pin_go),
    .o_pins(i_ext_clock), .o_busy(pin_busy));
  always #2 i_mclk = ~i_mclk;
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Write holds the strobe one cycle, then idles one so strobes never merge
  task automatic wr(input logic [6:0] a, input logic [1:0] b, input logic [15:0] d);
    i_addr <= a;
    i_be <= b;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
    v = o_rdata;
    @(posedge i_mclk);
  endtask
  task automatic rc(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
    logic [15:0] v;
    rd(a, v);
    ck(v & m, e);
  endtask
  task automatic t_init();
    for (int c = 0; c < 5; c++) rc({c[2:0], OFF_CTRL}, 16'h0080, 16'h00FF);
    for (int c = 3; c < 5; c++) begin
      rc({c[2:0], OFF_BRA}, BR_RST);
      rc({c[2:0], OFF_BRB}, BR_RST);
    end
  endtask
  // Every clear, edge and source code, bit 7 written as zero
  task automatic t_fields();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[1:0], i[1:0], i[2:0]};
      wr(7'h10, 2'b01, {8'h00, v});
      rc(7'h10, {8'h00, v | 8'h80}, 16'h00FF);
    end
  endtask
  task automatic t_bytes();
    wr(7'h3C, 2'b11, 16'h1234);
    wr(7'h3C, 2'b10, 16'hAB00);
    rc(7'h3C, 16'hAB34);
    wr(7'h4A, 2'b01, 16'h00CD);
    rc(7'h4A, 16'hFFCD);
    rc(7'h0A, RD_UNMAPPED);
    rc(7'h3B, RD_UNMAPPED);
  endtask
  // Two reads 16 cycles apart; falling-edge select must not matter
  task automatic t_presc();
    logic [15:0] a, b;
    for (int s = 0; s < 4; s++) begin
      wr(7'h00, 2'b01, {8'h00, 5'b00001, s[2:0]});
      rd(7'h04, a);
      repeat (13) @(posedge i_mclk);
      rd(7'h04, b);
      ck(b - a, 16'd16 >> s);
    end
  endtask
  task automatic t_ext();
    logic [1:0] p, e;
    int n;
    for (int k = 0; k < 6; k++) begin
      p = (k < 4) ? k[1:0] : 2'd0;
      e = (k < 4) ? 2'b10 : {1'b0, k[0]};
      pin_sel <= p;
      wr(7'h10, 2'b01, {11'h000, e, 1'b1, p});
      wr(7'h14, 2'b11, 16'h0000);
      pin_go <= 1'b1;
      @(posedge i_mclk);
      pin_go <= 1'b0;
      n = 0;
      do begin
        @(negedge i_mclk);
        n++;
      end while (pin_busy && n < 100);
      if (n >= 100) begin
        n_errors++;
        close_out();
      end
      repeat (8) @(posedge i_mclk);
      rc(7'h14, (k < 4) ? 16'd8 : 16'd4);
    end
  endtask
  // Channel 3 buffered, channel 4 not; both clear on A match
  task automatic t_cmp();
    logic [15:0] v;
    int n;
    wr(ADDR_FCR, 2'b01, 16'h0001);
    for (int c = 3; c < 5; c++) begin
      wr({c[2:0], OFF_GRA}, 2'b11, 16'd20);
      wr({c[2:0], OFF_BRA}, 2'b11, 16'd50);
      wr({c[2:0], OFF_CTRL}, 2'b01, 16'h0020);
      wr({c[2:0], OFF_CNT}, 2'b11, 16'h0000);
      n = 0;
      while (o_cmatch_a[c] !== 1'b1 && n < 60) begin
        @(negedge i_mclk);
        n++;
      end
      if (n >= 60) begin
        n_errors++;
        close_out();
      end
      @(posedge i_mclk);
      rc({c[2:0], OFF_GRA}, (c == 3) ? 16'd50 : 16'd20);
      rd({c[2:0], OFF_CNT}, v);
      ck(16'(v < 16'd20), 16'h0001);
    end
  endtask
  task automatic t_cap();
    wr(ADDR_FCR, 2'b01, 16'h0002);
    wr(7'h32, 2'b01, 16'h0040);
    rc(7'h32, 16'h00C8, 16'h00FF);
    wr(7'h38, 2'b11, 16'h1111);
    i_capture_b <= 5'h08;
    @(posedge i_mclk);
    i_capture_b <= 5'h00;
    @(posedge i_mclk);
    rc(7'h3C, 16'h1111);
  endtask
  // Phase steps only; the selected system clock must not count
  task automatic t_phase();
    i_quad_count_mode <= 1'b1;
    wr(7'h20, 2'b01, 16'h0000);
    wr(7'h24, 2'b11, 16'h0000);
    repeat (3) begin
      i_phase_up <= 1'b1;
      @(posedge i_mclk);
      i_phase_up <= 1'b0;
      @(posedge i_mclk);
    end
    i_phase_down <= 1'b1;
    @(posedge i_mclk);
    i_phase_down <= 1'b0;
    @(posedge i_mclk);
    rc(7'h24, 16'd2);
    i_quad_count_mode <= 1'b0;
  endtask
  // Channel 0 clears on B match; channel 1 follows by synchronous clear
  task automatic t_sync();
    logic [15:0] v;
    int n;
    wr(ADDR_SYNC, 2'b01, 16'h0003);
    wr(7'h08, 2'b11, 16'd10);
    wr(7'h10, 2'b01, 16'h0060);
    wr(7'h14, 2'b11, 16'h1000);
    wr(7'h00, 2'b01, 16'h0040);
    wr(7'h04, 2'b11, 16'h0000);
    n = 0;
    while (o_cmatch_b[0] !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 60) begin
      n_errors++;
      close_out();
    end
    @(negedge i_mclk);
    ck({15'h0000, o_cmatch_b[0]}, 16'h0000);
    @(posedge i_mclk);
    rd(7'h14, v);
    ck(16'(v < 16'd10), 16'h0001);
    rc(7'h08, 16'd10);
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    t_init();
    t_fields();
    t_bytes();
    t_presc();
    t_ext();
    t_cmp();
    t_cap();
    t_phase();
    t_sync();
    i_standby <= 1'b1;
    @(posedge i_mclk);
    i_standby <= 1'b0;
    t_init();
    rc(ADDR_FCR, 16'h0000, 16'h000F);
    close_out();
  end
endmodule

//--- tb/tcc_timer_core_monitor.sv
`timescale 1ns/100ps
module tcc_timer_core_monitor
  import tcc_pkg::*;
#(
  parameter int NCH = TCC_NCH
) (
  input wire logic           i_mclk,
  input wire logic           i_nrst,
  input wire logic           i_standby,
  input wire logic [6:0]     i_addr,
  input wire logic           i_rd,
  input wire logic [15:0]    o_rdata,
  input wire logic [NCH-1:0] o_cmatch_a,
  input wire logic [NCH-1:0] o_cmatch_b
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Channel and offset of the current access
  wire logic [2:0] ch  = i_addr[6:4];
  wire logic [3:0] off = i_addr[3:0];
  // Read data may only move after a read strobe
  property p_rd_hold;
    !i_rd && !$past(i_rd) && !i_standby |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_stby;
    i_standby |=> o_rdata == 16'h0000 && o_cmatch_a == '0 && o_cmatch_b == '0;
  endproperty
  a_stby: assert property (p_stby) else $error("standby left outputs set");
  property p_ctrl_fix;
    i_rd && ch < 3'd5 && off == OFF_CTRL |=> ##[0:1] o_rdata[CTRL_FIXED];
  endproperty
  a_ctrl_fix: assert property (p_ctrl_fix) else $error("control bit 7 low");
  property p_ioc_fix;
    i_rd && ch < 3'd5 && off == OFF_IOC |=> ##[0:1] (o_rdata[7] && o_rdata[3]);
  endproperty
  a_ioc_fix: assert property (p_ioc_fix) else $error("io control fixed bits low");
  property p_odd;
    i_rd && i_addr[0] |=> ##[0:1] o_rdata == RD_UNMAPPED;
  endproperty
  a_odd: assert property (p_odd) else $error("odd address read not zero");
  property p_nobuf;
    i_rd && ch < 3'd3 && (off == OFF_BRA || off == OFF_BRB) |=> ##[0:1] o_rdata == 16'h0000;
  endproperty
  a_nobuf: assert property (p_nobuf) else $error("buffer exists on low channel");
  // Match is flagged on arrival only, never two cycles running
  property p_cma;
    o_cmatch_a != '0 |=> (o_cmatch_a & $past(o_cmatch_a)) == '0;
  endproperty
  a_cma: assert property (p_cma) else $error("match A held");
  property p_cmb;
    (o_cmatch_b & $past(o_cmatch_b)) == '0;
  endproperty
  a_cmb: assert property (p_cmb) else $error("match B held");
endmodule

bind tcc_timer_core tcc_timer_core_monitor #(.NCH(NCH)) mon_u (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_standby(i_standby), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_cmatch_a(o_cmatch_a), .o_cmatch_b(o_cmatch_b));

//--- verilog/tcc_pkg.sv
package tcc_pkg;

  // Channel count and the first channel that owns buffer registers
  localparam int          TCC_NCH       = 5;
  localparam int          TCC_BUF_CH_LO = 3;

  // Per-channel register offsets (byte address bits 3:0)
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_IOC       = 4'h2;
  localparam logic [3:0]  OFF_CNT       = 4'h4;
  localparam logic [3:0]  OFF_GRA       = 4'h6;
  localparam logic [3:0]  OFF_GRB       = 4'h8;
  localparam logic [3:0]  OFF_BRA       = 4'hA;
  localparam logic [3:0]  OFF_BRB       = 4'hC;

  // Unit-wide registers (full byte address)
  localparam logic [6:0]  ADDR_FCR      = 7'h50;
  localparam logic [6:0]  ADDR_SYNC     = 7'h52;

  // Values after reset and standby entry
  localparam logic [7:0]  CTRL_RST      = 8'h80;
  localparam logic [7:0]  IOC_RST       = 8'h88;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  localparam logic [15:0] GR_RST        = 16'hFFFF;
  localparam logic [15:0] BR_RST        = 16'hFFFF;
  localparam logic [15:0] RD_UNMAPPED   = 16'h0000;

  // Control register field positions
  localparam int          CTRL_FIXED    = 7;
  localparam int          CTRL_CLR_HI   = 6;
  localparam int          CTRL_CLR_LO   = 5;
  localparam int          CTRL_EDGE_HI  = 4;
  localparam int          CTRL_EDGE_LO  = 3;
  localparam int          CTRL_SRC_HI   = 2;
  localparam int          CTRL_SRC_LO   = 0;

  // I/O control: bit set selects input capture for that register
  localparam int          IOC_B_CAPTURE = 6;
  localparam int          IOC_A_CAPTURE = 2;

  // Function control buffer enable bit positions
  localparam int          FCR_BUF_A3    = 0;
  localparam int          FCR_BUF_B3    = 1;
  localparam int          FCR_BUF_A4    = 2;
  localparam int          FCR_BUF_B4    = 3;

  // Counter clear source
  typedef enum logic [1:0] {
    TCC_CLR_NONE = 2'b00,
    TCC_CLR_GRA  = 2'b01,
    TCC_CLR_GRB  = 2'b10,
    TCC_CLR_SYNC = 2'b11
  } tcc_clear_sel_t;

  // Counter clock source
  typedef enum logic [2:0] {
    TCC_SRC_DIV1 = 3'b000,
    TCC_SRC_DIV2 = 3'b001,
    TCC_SRC_DIV4 = 3'b010,
    TCC_SRC_DIV8 = 3'b011,
    TCC_SRC_EXTA = 3'b100,
    TCC_SRC_EXTB = 3'b101,
    TCC_SRC_EXTC = 3'b110,
    TCC_SRC_EXTD = 3'b111
  } tcc_clk_src_t;

  // External edge selection (1x counts both edges)
  typedef enum logic [1:0] {
    TCC_EDGE_RISE  = 2'b00,
    TCC_EDGE_FALL  = 2'b01,
    TCC_EDGE_BOTH  = 2'b10,
    TCC_EDGE_BOTH2 = 2'b11
  } tcc_edge_sel_t;

endpackage

//--- verilog/tcc_timer_core.sv
`timescale 1ns/100ps

module tcc_timer_core
  import tcc_pkg::*;
#(
  parameter int NCH = TCC_NCH                 // Number of timer channels
) (
  input  wire logic              i_mclk,        // System clock
  input  wire logic              i_nrst,        // Synchronous reset, active low
  input  wire logic              i_standby,     // Standby entry, same effect as reset except the pin synchronisers
  input  wire logic [6:0]        i_addr,        // Register byte address
  input  wire logic              i_wr,          // Write strobe
  input  wire logic              i_rd,          // Read strobe
  input  wire logic [1:0]        i_be,          // Byte lanes: bit1 upper, bit0 lower
  input  wire logic [15:0]       i_wdata,       // Write data
  input  wire logic [3:0]        i_ext_clock,   // External clock pins A..D (async)
  input  wire logic [NCH-1:0]    i_capture_a,   // Capture strobes for general A
  input  wire logic [NCH-1:0]    i_capture_b,   // Capture strobes for general B
  input  wire logic              i_quad_count_mode, // Channel 2 phase counting
  input  wire logic              i_phase_up,    // Phase counter up step
  input  wire logic              i_phase_down,  // Phase counter down step
  output logic [15:0]            o_rdata,       // Read data, registered
  output logic [NCH-1:0]         o_cmatch_a,    // Compare match A, one cycle late
  output logic [NCH-1:0]         o_cmatch_b     // Compare match B, one cycle late
);

  // Merge bus data into a 16-bit register by byte lane
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
    lane_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  logic              rst_any;                  // Reset or standby entry
  logic [2:0]        presc_reg;                // Free-running prescaler
  logic [3:0]        ext_s1_reg;               // First synchroniser stage
  logic [3:0]        ext_s2_reg;               // Second synchroniser stage
  logic [3:0]        ext_s3_reg;               // History for edge detection
  logic [3:0]        ext_rise;                 // Rising edge seen on pin
  logic [3:0]        ext_fall;                 // Falling edge seen on pin
  logic [3:0]        fcr_reg;                  // Buffer enable bits
  logic [NCH-1:0]    sync_reg;                 // Synchronous operation select
  logic [NCH-1:0]    sync_src;                 // Own clear of a synced channel
  logic              sync_any;                 // Any synced channel cleared
  logic [3:0]        buf_en_w [NCH];           // Buffer enable per channel (A,B)
  logic [15:0]       rd_ch_w  [NCH];           // Per-channel read value
  logic [NCH-1:0]    match_a_w;                // Compare match A pulse
  logic [NCH-1:0]    match_b_w;                // Compare match B pulse
  logic [2:0]        rd_ch;                    // Addressed channel
  logic [3:0]        rd_off;                   // Offset within channel
  logic [15:0]       rd_mux;                   // Selected read value

  // Standby entry clears the same state as reset; pin synchronisers keep running
  assign rst_any = !i_nrst || i_standby;

  // Prescaler counts every cycle; divided ticks mark its wrap points
  // Wraps every eight cycles, so all divided ticks stay in a fixed phase
  always_ff @(posedge i_mclk) begin
    if (rst_any) begin
      presc_reg <= 3'h0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // Two flops then a history flop; stage two and the history flop feed the edge logic
  // Nothing but the second stage reads the first, so metastability stays contained
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
      ext_s3_reg <= 4'h0;
    end else begin
      ext_s1_reg <= i_ext_clock;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_rise = ext_s2_reg & ~ext_s3_reg;
  assign ext_fall = ~ext_s2_reg & ext_s3_reg;

  // Unit-wide buffer enable and synchronisation registers
  // Both are lane 0 registers of 4 and NCH bits; an upper-lane write is dropped
  always_ff @(posedge i_mclk) begin
    if (rst_any) begin
      fcr_reg  <= 4'h0;
      sync_reg <= '0;
    end else if (i_wr && i_be[0] && i_addr == ADDR_FCR) begin
      fcr_reg  <= i_wdata[3:0];
    end else if (i_wr && i_be[0] && i_addr == ADDR_SYNC) begin
      sync_reg <= i_wdata[NCH-1:0];
    end
  end

  // A synced channel's own clear is broadcast to every synced channel whose clear select is synchronous clear
  assign sync_any = |sync_src;

  // Per-channel counter, control and general/buffer registers
  for (genvar ch = 0; ch < NCH; ch++) begin : gen_ch
    logic [6:0]   ctrl_reg;                   // Control bits 6:0; bit 7 is fixed
    logic [5:0]   ioc_reg;                    // I/O control B[2:0], A[2:0]
    logic [15:0]  cnt_reg;                    // Count value
    logic [15:0]  cnt_next;
    logic [15:0]  gra_reg;                    // General register A
    logic [15:0]  gra_next;
    logic [15:0]  grb_reg;                    // General register B
    logic [15:0]  grb_next;
    logic [15:0]  bra_w;                      // Buffer A value (or ones)
    logic [15:0]  brb_w;                      // Buffer B value (or ones)
    logic         eq_a_reg;                   // Last-cycle equality, A
    logic         eq_b_reg;                   // Last-cycle equality, B
    logic         eq_a;
    logic         eq_b;
    logic         cap_mode_a;                 // A acts as input capture
    logic         cap_mode_b;                 // B acts as input capture
    logic         cap_a;
    logic         cap_b;
    logic         clr_own;                    // Clear from own A/B event
    logic         clr_hit;                    // Final clear of count
    logic         int_tick;                   // Internal clock falling edge
    logic         ext_tick;                   // Selected external edge
    logic         up_step;
    logic         down_step;
    logic         quad;                       // Phase counting owns the count
    logic         wr_ch;                      // Write to this channel
    logic [1:0]   clr_sel;
    logic [1:0]   edge_sel;
    logic [2:0]   src_sel;

    // Channel decode and field split of the control register
    assign wr_ch      = i_wr && i_addr[6:4] == 3'(ch);
    assign clr_sel    = ctrl_reg[CTRL_CLR_HI:CTRL_CLR_LO];
    assign edge_sel   = ctrl_reg[CTRL_EDGE_HI:CTRL_EDGE_LO];
    assign src_sel    = ctrl_reg[CTRL_SRC_HI:CTRL_SRC_LO];
    assign quad       = (ch == 2) && i_quad_count_mode;
    assign cap_mode_a = ioc_reg[IOC_A_CAPTURE];
    assign cap_mode_b = ioc_reg[IOC_B_CAPTURE - 1];

    // Prescaled internal tick, falling edge of the divided clock only
    assign int_tick = (src_sel == TCC_SRC_DIV1) ? 1'b1 :
                      (src_sel == TCC_SRC_DIV2) ? presc_reg[0] :
                      (src_sel == TCC_SRC_DIV4) ? &presc_reg[1:0] :
                      &presc_reg[2:0];

    // External tick by selected pin and edge field
    assign ext_tick = edge_sel[1] ? (ext_rise[src_sel[1:0]] | ext_fall[src_sel[1:0]]) :
                      edge_sel[0] ? ext_fall[src_sel[1:0]] :
                      ext_rise[src_sel[1:0]];

    // Phase counting takes the count over; up wins when both steps arrive
    assign up_step   = quad ? i_phase_up :
                       (src_sel[2] ? ext_tick : int_tick);
    assign down_step = quad && i_phase_down && !i_phase_up;

    // Match is taken on arrival at equality, once per visit
    // A level compare would fire again on every stalled cycle of a slow clock
    assign eq_a         = cnt_reg == gra_reg;
    assign eq_b         = cnt_reg == grb_reg;
    assign match_a_w[ch] = !cap_mode_a && eq_a && !eq_a_reg;
    assign match_b_w[ch] = !cap_mode_b && eq_b && !eq_b_reg;
    assign cap_a        = cap_mode_a && i_capture_a[ch];
    assign cap_b        = cap_mode_b && i_capture_b[ch];

    // Own clear event from A or B in its current role
    assign clr_own = (clr_sel == TCC_CLR_GRA && (match_a_w[ch] || cap_a)) ||
                     (clr_sel == TCC_CLR_GRB && (match_b_w[ch] || cap_b));
    assign sync_src[ch] = sync_reg[ch] && clr_own;
    assign clr_hit = clr_own ||
                     (clr_sel == TCC_CLR_SYNC && sync_reg[ch] && sync_any);

    // Count: clear beats a bus write, which beats a count step
    assign cnt_next = clr_hit ? CNT_RST :
                      (wr_ch && i_addr[3:0] == OFF_CNT) ? lane_merge(cnt_reg, i_wdata, i_be) :
                      up_step ? cnt_reg + 16'h0001 :
                      down_step ? cnt_reg - 16'h0001 : cnt_reg;

    // General A: capture, then buffered reload, then bus write
    // A bus write in the same cycle as a hardware event is lost on purpose
    assign gra_next = cap_a ? cnt_reg :
                      (buf_en_w[ch][0] && match_a_w[ch]) ? bra_w :
                      (wr_ch && i_addr[3:0] == OFF_GRA) ? lane_merge(gra_reg, i_wdata, i_be) :
                      gra_reg;
    assign grb_next = cap_b ? cnt_reg :
                      (buf_en_w[ch][1] && match_b_w[ch]) ? brb_w :
                      (wr_ch && i_addr[3:0] == OFF_GRB) ? lane_merge(grb_reg, i_wdata, i_be) :
                      grb_reg;

    // Control, I/O control, count and general registers
    // Fixed bits of control and I/O control are not stored at all
    always_ff @(posedge i_mclk) begin
      if (rst_any) begin
        ctrl_reg <= CTRL_RST[6:0];
        ioc_reg  <= {IOC_RST[6:4], IOC_RST[2:0]};
        cnt_reg  <= CNT_RST;
        gra_reg  <= GR_RST;
        grb_reg  <= GR_RST;
        eq_a_reg <= 1'b0;
        eq_b_reg <= 1'b0;
      end else begin
        if (wr_ch && i_be[0] && i_addr[3:0] == OFF_CTRL) begin
          ctrl_reg <= i_wdata[6:0];
        end
        if (wr_ch && i_be[0] && i_addr[3:0] == OFF_IOC) begin
          ioc_reg <= {i_wdata[6:4], i_wdata[2:0]};
        end
        cnt_reg  <= cnt_next;
        gra_reg  <= gra_next;
        grb_reg  <= grb_next;
        eq_a_reg <= eq_a;
        eq_b_reg <= eq_b;
      end
    end

    // Buffer registers exist only on the upper two channels
    if (ch >= TCC_BUF_CH_LO) begin : gen_buf
      logic [15:0] bra_reg;                   // Buffer A
      logic [15:0] brb_reg;                   // Buffer B

      // Capture side moves the old general value; bus may write otherwise
      always_ff @(posedge i_mclk) begin
        if (rst_any) begin
          bra_reg <= BR_RST;
          brb_reg <= BR_RST;
        end else begin
          if (buf_en_w[ch][0] && cap_a) begin
            bra_reg <= gra_reg;
          end else if (wr_ch && i_addr[3:0] == OFF_BRA) begin
            bra_reg <= lane_merge(bra_reg, i_wdata, i_be);
          end
          if (buf_en_w[ch][1] && cap_b) begin
            brb_reg <= grb_reg;
          end else if (wr_ch && i_addr[3:0] == OFF_BRB) begin
            brb_reg <= lane_merge(brb_reg, i_wdata, i_be);
          end
        end
      end
      assign bra_w = bra_reg;
      assign brb_w = brb_reg;
      assign buf_en_w[ch] = (ch == TCC_BUF_CH_LO) ?
                            {2'b00, fcr_reg[FCR_BUF_B3], fcr_reg[FCR_BUF_A3]} :
                            {2'b00, fcr_reg[FCR_BUF_B4], fcr_reg[FCR_BUF_A4]};
    end else begin : gen_nobuf
      // Lower channels have no buffers; constants keep the shared muxes simple
      assign bra_w = BR_RST;
      assign brb_w = BR_RST;
      assign buf_en_w[ch] = 4'h0;
    end

    // Per-channel read selection; fixed bits read as one
    assign rd_ch_w[ch] =
      (i_addr[3:0] == OFF_CTRL) ? {8'h00, 1'b1, ctrl_reg} :
      (i_addr[3:0] == OFF_IOC)  ? {8'h00, 1'b1, ioc_reg[5:3], 1'b1, ioc_reg[2:0]} :
      (i_addr[3:0] == OFF_CNT)  ? cnt_reg :
      (i_addr[3:0] == OFF_GRA)  ? gra_reg :
      (i_addr[3:0] == OFF_GRB)  ? grb_reg :
      (i_addr[3:0] == OFF_BRA && ch >= TCC_BUF_CH_LO) ? bra_w :
      (i_addr[3:0] == OFF_BRB && ch >= TCC_BUF_CH_LO) ? brb_w :
      RD_UNMAPPED;
  end

  // Top-level read decode
  // Unit-wide registers sit just above the last channel's address range
  assign rd_ch  = i_addr[6:4];
  assign rd_off = i_addr[3:0];
  assign rd_mux = (i_addr == ADDR_FCR)  ? {12'h000, fcr_reg} :
                  (i_addr == ADDR_SYNC) ? {{(16-NCH){1'b0}}, sync_reg} :
                  (32'(rd_ch) < NCH && !rd_off[0]) ? rd_ch_w[rd_ch] :
                  RD_UNMAPPED;

  // Read data and match outputs are registered; data holds between reads
  // Match outputs lag the internal event by one cycle so they come from flops
  always_ff @(posedge i_mclk) begin
    if (rst_any) begin
      o_rdata    <= RD_UNMAPPED;
      o_cmatch_a <= '0;
      o_cmatch_b <= '0;
    end else begin
      if (i_rd) begin
        o_rdata <= rd_mux;
      end
      o_cmatch_a <= match_a_w;
      o_cmatch_b <= match_b_w;
    end
  end

endmodule
